// [rtl/mpag_addr_form.sv]
// Page address former: builds the pointer or operand location of a memory
// reference instruction. Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module mpag_addr_form (
  input wire logic [mpag_pkg::ADDR_W-1:0] ma_in,
  input wire mpag_pkg::mpag_instr_t instr_in,
  output logic [mpag_pkg::ADDR_W-1:0] addr_out
);

  // ----------------------------------------------------------------
  // Page select
  // ----------------------------------------------------------------
  // The opcode field is ignored here on purpose; only page bit and offset matter.
  always_comb begin
    if (instr_in.cur_page) begin
      addr_out = {ma_in[mpag_pkg::ADDR_W-1:mpag_pkg::OFFS_W], instr_in.offset};
    end else begin
      addr_out = {mpag_pkg::PAGE_ZERO, instr_in.offset};
    end
  end

endmodule // mpag_addr_form
`default_nettype wire

// [rtl/mpag_autoidx_det.sv]
// Auto-index detector: flags indirect references through locations 0010-0017 octal.
// The incrementing itself belongs to a separate unit fed by the flag.
`timescale 1ns/1ps
`default_nettype none
module mpag_autoidx_det (
  input wire logic [mpag_pkg::ADDR_W-1:0] ptr_addr_in,
  input wire logic indirect_in,
  output logic hit_out
);

  // ----------------------------------------------------------------
  // Range compare
  // ----------------------------------------------------------------
  // Only indirect references count; a direct access to these words is ordinary.
  assign hit_out = indirect_in && (ptr_addr_in >= mpag_pkg::AUTOIDX_LO) &&
                   (ptr_addr_in <= mpag_pkg::AUTOIDX_HI);

endmodule // mpag_autoidx_det
`default_nettype wire

// [rtl/mpag_pkg.sv]
// Shared constants and types for the page address generation block.
// Assumes a single 40 MHz processor clock and a word-organised core memory partner.
package mpag_pkg;

  // ----------------------------------------------------------------
  // Word and address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int WORD_W = 12;
  localparam int PAGE_W = 5;
  localparam int OFFS_W = 7;
  localparam int OPC_W = 3;
  localparam logic [PAGE_W-1:0] PAGE_ZERO = 5'h00;
  localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] PC_STEP = 12'h001;

  // ----------------------------------------------------------------
  // Special locations and opcodes
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] INT_SAVE_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] INT_VECTOR = 12'h001;
  localparam logic [ADDR_W-1:0] AUTOIDX_LO = 12'h008;
  localparam logic [ADDR_W-1:0] AUTOIDX_HI = 12'h00F;
  localparam logic [OPC_W-1:0] OPC_JMP = 3'h5;
  localparam logic [OPC_W-1:0] OPC_FIRST_NON_MRI = 3'h6;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam int BUS_AW = 5;
  localparam logic [BUS_AW-1:0] REG_CTRL = 5'h00;
  localparam logic [BUS_AW-1:0] REG_PC = 5'h04;
  localparam logic [BUS_AW-1:0] REG_STATUS = 5'h08;
  localparam logic [BUS_AW-1:0] REG_MA = 5'h0C;
  localparam logic [BUS_AW-1:0] REG_EA = 5'h10;
  localparam logic [BUS_AW-1:0] REG_INSTR = 5'h14;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_INT_BIT = 1;
  localparam int STAT_AUTOIDX_BIT = 0;
  localparam int STAT_INTDONE_BIT = 1;
  localparam int STAT_INTPEND_BIT = 2;
  localparam int STAT_STATE_LSB = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Instruction word, most significant bit (bit 0 in processor numbering) first.
  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic indirect;
    logic cur_page;
    logic [OFFS_W-1:0] offset;
  } mpag_instr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mpag_mem_req_t;

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_IWAIT, S_DECODE, S_DEFER, S_DWAIT,
    S_EXEC, S_OWAIT, S_NEXT, S_INT, S_INTWAIT
  } mpag_state_t;

endpackage

// [rtl/mpag_top.sv]
// Processor address sequencer: fetch, page address formation, defer cycle,
// operand access and interrupt save, with an Avalon-MM register slave.
// Assumes memory holds a request until it pulses MEM_ACK_IN for one cycle.
//
// How it works
// - All formed addresses are 12 bits, covering 4096 words.
// - Memory is 32 pages of 128 words each.
// - Address register holds page in top 5 bits, offset in low 7.
// - Each fetch loads the whole address register from the program counter.
// - Top three instruction bits are the opcode and do not shape addresses.
// - Low seven instruction bits give the in-page location.
// - Offset reaches the address register only after page and indirect bits decode.
// - Current page is the page held in the address register at fetch.
// - Page bit one keeps the page and replaces the offset.
// - Page bit zero clears the page and loads the offset.
// - Indirect bit zero gives a direct operand address, one a pointer.
// - Indirect bit set enters a defer state to fetch a new address.
// - Defer reads the pointer and uses all 12 bits as effective address.
// - Interrupt saves the program counter into location zero.
// - After the save, execution resumes at location one.
// - Fetch moves the counter to the address register then increments it.
// - A jump loads the effective address into the program counter.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mpag_top (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [mpag_pkg::BUS_AW-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic [mpag_pkg::WORD_W-1:0] MEM_RDATA_IN,
  input wire logic MEM_ACK_IN,
  output logic [mpag_pkg::ADDR_W-1:0] MEM_ADDR_OUT,
  output logic MEM_RD_OUT,
  output logic MEM_WR_OUT,
  output logic [mpag_pkg::WORD_W-1:0] MEM_WDATA_OUT,
  output logic AUTOINDEX_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mpag_pkg::mpag_state_t state_q;
  mpag_pkg::mpag_mem_req_t mem_q;
  mpag_pkg::mpag_instr_t instr;
  logic [mpag_pkg::ADDR_W-1:0] pc_q;
  logic [mpag_pkg::ADDR_W-1:0] ma_q;
  logic [mpag_pkg::ADDR_W-1:0] ea_q;
  logic [mpag_pkg::WORD_W-1:0] mb_q;
  logic [mpag_pkg::ADDR_W-1:0] formed;
  logic auto_hit;
  logic is_mri;
  logic run_q;
  logic int_pend_q;
  logic autoidx_sticky_q;
  logic int_done_q;
  logic autoindex_q;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  logic bus_wr;
  logic bus_rd;
  logic int_served;

  // ----------------------------------------------------------------
  // Instruction view and address helpers
  // ----------------------------------------------------------------
  // The page bit, indirect bit and offset are only interpreted in decode, so the offset never leaks early.
  assign instr = mpag_pkg::mpag_instr_t'(mb_q);
  assign is_mri = (instr.opcode < mpag_pkg::OPC_FIRST_NON_MRI);

  mpag_addr_form u_form (
    .ma_in(ma_q),
    .instr_in(instr),
    .addr_out(formed)
  );

  mpag_autoidx_det u_auto (
    .ptr_addr_in(formed),
    .indirect_in(instr.indirect),
    .hit_out(auto_hit)
  );

  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  // A request is taken only while waitrequest is high, so each access acts once.
  assign bus_wr = AVS_WRITE_IN && waitreq_q;
  assign bus_rd = AVS_READ_IN && waitreq_q;
  assign int_served = (state_q == mpag_pkg::S_INTWAIT) && MEM_ACK_IN;

  // Byte enables become a bit mask, one lane per generate step.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign be_mask[8*g+7:8*g] = {8{AVS_BYTEENABLE_IN[g]}};
  end

  // Merge of write data over the current content of the addressed register.
  always_comb begin
    wr_val = (rd_mux & ~be_mask) | (AVS_WRITEDATA_IN & be_mask);
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_IN)
      mpag_pkg::REG_CTRL: begin
        rd_mux[mpag_pkg::CTRL_RUN_BIT] = run_q;
      end
      mpag_pkg::REG_PC: rd_mux[mpag_pkg::ADDR_W-1:0] = pc_q;
      mpag_pkg::REG_STATUS: begin
        rd_mux[mpag_pkg::STAT_AUTOIDX_BIT] = autoidx_sticky_q;
        rd_mux[mpag_pkg::STAT_INTDONE_BIT] = int_done_q;
        rd_mux[mpag_pkg::STAT_INTPEND_BIT] = int_pend_q;
        rd_mux[mpag_pkg::STAT_STATE_LSB+3:mpag_pkg::STAT_STATE_LSB] = state_q;
      end
      mpag_pkg::REG_MA: rd_mux[mpag_pkg::ADDR_W-1:0] = ma_q;
      mpag_pkg::REG_EA: rd_mux[mpag_pkg::ADDR_W-1:0] = ea_q;
      mpag_pkg::REG_INSTR: rd_mux[mpag_pkg::WORD_W-1:0] = mb_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Avalon-MM answer
  // ----------------------------------------------------------------
  // Fixed one-cycle answer: waitrequest drops in the cycle after the request.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (!waitreq_q) begin
      waitreq_q <= 1'b1;
    end else if (AVS_READ_IN || AVS_WRITE_IN) begin
      waitreq_q <= 1'b0;
      rdata_q <= AVS_READ_IN ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Control and sticky flags
  // ----------------------------------------------------------------
  // Hardware sets win over software clears so no event is lost.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      run_q <= 1'b0;
      int_pend_q <= 1'b0;
      autoidx_sticky_q <= 1'b0;
      int_done_q <= 1'b0;
    end else begin
      if (bus_wr && AVS_ADDRESS_IN == mpag_pkg::REG_CTRL) begin
        run_q <= wr_val[mpag_pkg::CTRL_RUN_BIT];
      end
      if (bus_wr && AVS_ADDRESS_IN == mpag_pkg::REG_CTRL && wr_val[mpag_pkg::CTRL_INT_BIT]) begin
        int_pend_q <= 1'b1;
      end else if (int_served) begin
        int_pend_q <= 1'b0;
      end
      if (state_q == mpag_pkg::S_DECODE && is_mri && auto_hit) begin
        autoidx_sticky_q <= 1'b1;
      end else if (bus_wr && AVS_ADDRESS_IN == mpag_pkg::REG_STATUS &&
                   AVS_WRITEDATA_IN[mpag_pkg::STAT_AUTOIDX_BIT] && AVS_BYTEENABLE_IN[0]) begin
        autoidx_sticky_q <= 1'b0;
      end
      if (int_served) begin
        int_done_q <= 1'b1;
      end else if (bus_wr && AVS_ADDRESS_IN == mpag_pkg::REG_STATUS &&
                   AVS_WRITEDATA_IN[mpag_pkg::STAT_INTDONE_BIT] && AVS_BYTEENABLE_IN[0]) begin
        int_done_q <= 1'b0;
      end
    end
  end

  // Auto-index pulse for the external incrementing unit.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      autoindex_q <= 1'b0;
    end else begin
      autoindex_q <= (state_q == mpag_pkg::S_DECODE) && is_mri && auto_hit;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer with address and memory request registers
  // ----------------------------------------------------------------
  // Memory requests are held until the one-cycle acknowledge, then dropped.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      state_q <= mpag_pkg::S_IDLE;
      pc_q <= mpag_pkg::PC_RESET;
      ma_q <= mpag_pkg::PC_RESET;
      ea_q <= mpag_pkg::PC_RESET;
      mb_q <= 12'h000;
      mem_q <= '0;
    end else begin
      case (state_q)
        mpag_pkg::S_IDLE: begin
          if (bus_wr && AVS_ADDRESS_IN == mpag_pkg::REG_PC) begin
            pc_q <= wr_val[mpag_pkg::ADDR_W-1:0];
          end else if (run_q && int_pend_q) begin
            state_q <= mpag_pkg::S_INT;
          end else if (run_q) begin
            state_q <= mpag_pkg::S_FETCH;
          end
        end
        mpag_pkg::S_FETCH: begin
          ma_q <= pc_q;
          pc_q <= pc_q + mpag_pkg::PC_STEP;
          mem_q <= '{rd: 1'b1, wr: 1'b0, addr: pc_q, wdata: 12'h000};
          state_q <= mpag_pkg::S_IWAIT;
        end
        mpag_pkg::S_IWAIT: begin
          if (MEM_ACK_IN) begin
            mb_q <= MEM_RDATA_IN;
            mem_q.rd <= 1'b0;
            state_q <= mpag_pkg::S_DECODE;
          end
        end
        mpag_pkg::S_DECODE: begin
          if (!is_mri) begin
            state_q <= mpag_pkg::S_NEXT;
          end else begin
            ma_q <= formed;
            if (instr.indirect) begin
              state_q <= mpag_pkg::S_DEFER;
            end else begin
              ea_q <= formed;
              state_q <= mpag_pkg::S_EXEC;
            end
          end
        end
        mpag_pkg::S_DEFER: begin
          mem_q <= '{rd: 1'b1, wr: 1'b0, addr: ma_q, wdata: 12'h000};
          state_q <= mpag_pkg::S_DWAIT;
        end
        mpag_pkg::S_DWAIT: begin
          if (MEM_ACK_IN) begin
            ea_q <= MEM_RDATA_IN;
            ma_q <= MEM_RDATA_IN;
            mem_q.rd <= 1'b0;
            state_q <= mpag_pkg::S_EXEC;
          end
        end
        mpag_pkg::S_EXEC: begin
          if (instr.opcode == mpag_pkg::OPC_JMP) begin
            pc_q <= ea_q;
            state_q <= mpag_pkg::S_NEXT;
          end else begin
            mem_q <= '{rd: 1'b1, wr: 1'b0, addr: ea_q, wdata: 12'h000};
            state_q <= mpag_pkg::S_OWAIT;
          end
        end
        mpag_pkg::S_OWAIT: begin
          if (MEM_ACK_IN) begin
            mem_q.rd <= 1'b0;
            state_q <= mpag_pkg::S_NEXT;
          end
        end
        mpag_pkg::S_NEXT: begin
          if (int_pend_q) begin
            state_q <= mpag_pkg::S_INT;
          end else if (run_q) begin
            state_q <= mpag_pkg::S_FETCH;
          end else begin
            state_q <= mpag_pkg::S_IDLE;
          end
        end
        mpag_pkg::S_INT: begin
          mem_q <= '{rd: 1'b0, wr: 1'b1, addr: mpag_pkg::INT_SAVE_ADDR, wdata: pc_q};
          state_q <= mpag_pkg::S_INTWAIT;
        end
        mpag_pkg::S_INTWAIT: begin
          if (MEM_ACK_IN) begin
            mem_q.wr <= 1'b0;
            pc_q <= mpag_pkg::INT_VECTOR;
            state_q <= mpag_pkg::S_NEXT;
          end
        end
        default: state_q <= mpag_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA_OUT = rdata_q;
  assign AVS_WAITREQUEST_OUT = waitreq_q;
  assign MEM_ADDR_OUT = mem_q.addr;
  assign MEM_RD_OUT = mem_q.rd;
  assign MEM_WR_OUT = mem_q.wr;
  assign MEM_WDATA_OUT = mem_q.wdata;
  assign AUTOINDEX_OUT = autoindex_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fetch_load_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_FETCH |=> ma_q == $past(pc_q) && MEM_RD_OUT && MEM_ADDR_OUT == ma_q)
    else $error("Fetch did not load the address register from the counter.");

  pc_step_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_FETCH |=> pc_q == $past(pc_q) + 12'h001)
    else $error("Counter did not advance by one at fetch.");

  offset_hold_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_IWAIT |=> $stable(ma_q))
    else $error("Address register changed before decode.");

  cur_page_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DECODE && is_mri && instr.cur_page |=>
      ma_q[11:7] == $past(ma_q[11:7]) && ma_q[6:0] == $past(mb_q[6:0]))
    else $error("Current page address formed wrongly.");

  page_zero_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DECODE && is_mri && !instr.cur_page |=>
      ma_q[11:7] == 5'h00 && ma_q[6:0] == $past(mb_q[6:0]))
    else $error("Page zero address formed wrongly.");

  direct_ea_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DECODE && is_mri && !instr.indirect |=>
      state_q == mpag_pkg::S_EXEC && ea_q == ma_q)
    else $error("Direct reference did not use the formed address.");

  defer_entry_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DECODE && is_mri && instr.indirect |=>
      state_q == mpag_pkg::S_DEFER ##1 MEM_RD_OUT && MEM_ADDR_OUT == $past(ma_q))
    else $error("Indirect reference skipped the defer read.");

  defer_ea_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DWAIT && MEM_ACK_IN |=> ea_q == $past(MEM_RDATA_IN))
    else $error("Pointer content not taken as effective address.");

  operand_addr_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_EXEC && instr.opcode != mpag_pkg::OPC_JMP |=>
      MEM_RD_OUT && MEM_ADDR_OUT == ea_q)
    else $error("Operand access not at the effective address.");

  jump_pc_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_EXEC && instr.opcode == mpag_pkg::OPC_JMP |=> pc_q == $past(ea_q))
    else $error("Jump did not load the counter.");

  int_save_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_INT |=> MEM_WR_OUT && MEM_ADDR_OUT == 12'h000 &&
      MEM_WDATA_OUT == $past(pc_q))
    else $error("Interrupt save not written to location zero.");

  int_vector_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    int_served |=> pc_q == 12'h001)
    else $error("Counter not set to location one after the save.");

  auto_flag_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    state_q == mpag_pkg::S_DECODE && is_mri && instr.indirect && formed >= 12'h008 &&
      formed <= 12'h00F |=> AUTOINDEX_OUT && autoidx_sticky_q)
    else $error("Auto-index reference not flagged.");

endmodule // mpag_top
`default_nettype wire

// [testbench/mpag_core_mem.sv]
// Behavioural word memory on the far side of the sequencer's memory link.
// Assumes each request is held until the acknowledge pulse that ends it.
`timescale 1ns/1ps
`default_nettype none
module mpag_core_mem (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic [11:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [11:0] wdata_in,
  output logic [11:0] rdata_out,
  output logic ack_out
);
  logic [11:0] words [0:4095];
  logic [11:0] last_q = 12'h000;
  logic [1:0] wait_q = 2'h0;

  // Answer after none or three wait cycles; a write lands as the pulse is raised.
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    if ((rd_in || wr_in) && !ack_out) begin
      if (wait_q >= (slow_in ? 2'h3 : 2'h0)) begin
        ack_out <= 1'b1;
        wait_q <= 2'h0;
        if (wr_in) begin
          words[addr_in] <= wdata_in;
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end

  // Outside the pulse the lines carry the inverse of the last word, so stale data never matches.
  assign rdata_out = ack_out ? words[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    if (ack_out) begin
      last_q <= rdata_out;
    end
  end
endmodule // mpag_core_mem
`default_nettype wire

// [testbench/mpag_top_bench.sv]
// Self-checking bench for the page address sequencer.
// Assumes the memory model beside it and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module mpag_top_bench;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic waitreq, m_rd, m_wr, m_ack, ai;
  logic [11:0] m_addr, m_wdat, m_rdat;
  logic [24:0] seen[$];
  int errors = 0, total_checks = 0, cycles = 0, ai_cnt = 0, i;
  // Read addresses of the first program, in order of the memory cycles.
  logic [11:0] exp_seq [0:12] = '{12'h080, 12'h028, 12'h081, 12'h090, 12'h082, 12'h028,
    12'h2BD, 12'h083, 12'h00A, 12'h555, 12'h084, 12'h0FF, 12'h100};

  initial begin
    forever #12.5 clk = ~clk;
  end

  mpag_top dut (.CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(waitreq), .MEM_RDATA_IN(m_rdat),
    .MEM_ACK_IN(m_ack), .MEM_ADDR_OUT(m_addr), .MEM_RD_OUT(m_rd), .MEM_WR_OUT(m_wr),
    .MEM_WDATA_OUT(m_wdat), .AUTOINDEX_OUT(ai));
  mpag_core_mem mem (.clk_in(clk), .slow_in(slow), .addr_in(m_addr), .rd_in(m_rd),
    .wr_in(m_wr), .wdata_in(m_wdat), .rdata_out(m_rdat), .ack_out(m_ack));

  // Log every completed memory cycle and count auto-index pulses; cut a hang short.
  always @(posedge clk) begin
    cycles++;
    if (m_ack && (m_rd || m_wr)) seen.push_back({m_wr, m_addr, m_wdat});
    if (ai === 1'b1) ai_cnt++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle: held until the rising edge that sees waitrequest low; data is taken
  // and the request dropped at that same edge, so the next call starts one cycle later.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_seen(input int n);
    repeat (2000) if (seen.size() < n) @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    // Program: direct page 0, direct current page, indirect, auto-index, jump, non-MEMORY_REFERENCE_INSTR.
    for (i = 0; i < 4096; i++) mem.words[i] = 12'h000;
    mem.words[12'h080] = 12'h228;
    mem.words[12'h081] = 12'h290;
    mem.words[12'h082] = 12'h328;
    mem.words[12'h083] = 12'h30A;
    mem.words[12'h084] = 12'hAFF;
    mem.words[12'h0FF] = 12'hE00;
    mem.words[12'h028] = 12'h2BD;
    mem.words[12'h00A] = 12'h555;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(0, mpag_pkg::REG_PC, 0); chk(q, 0);
    bus(0, 5'h18, 0); chk(q, 0);
    bus(1, mpag_pkg::REG_EA, 32'h123);
    bus(0, mpag_pkg::REG_EA, 0); chk(q, 0);
    bus(1, mpag_pkg::REG_PC, 32'h080);
    bus(1, mpag_pkg::REG_CTRL, 32'h1);
    wait_seen(13);
    for (i = 0; i < 13; i++) chk(seen[i][23:12], exp_seq[i]);
    bus(1, mpag_pkg::REG_CTRL, 32'h0);
    q = 32'hFF;
    for (i = 0; i < 100 && q[7:4] !== 4'(mpag_pkg::S_IDLE); i++) bus(0, mpag_pkg::REG_STATUS, 0);
    chk(q[0], 1);
    chk(ai_cnt, 1);
    bus(1, mpag_pkg::REG_STATUS, 32'h1);
    bus(0, mpag_pkg::REG_STATUS, 0); chk(q[0], 0);
    // Interrupt with a slow memory: save the counter at 0, then fetch from 1.
    slow <= 1'b1;
    bus(1, mpag_pkg::REG_PC, 32'h200);
    bus(0, mpag_pkg::REG_PC, 0); chk(q, 32'h200);
    seen.delete();
    bus(1, mpag_pkg::REG_CTRL, 32'h3);
    bus(0, mpag_pkg::REG_CTRL, 0); chk(q, 32'h1);
    wait_seen(2);
    chk(seen[0], {1'b1, 12'h000, 12'h200});
    chk(seen[1][24:12], {1'b0, 12'h001});
    bus(0, mpag_pkg::REG_STATUS, 0); chk(q[1], 1);
    summarize();
  end
endmodule // mpag_top_bench
`default_nettype wire
